// ===== dv/monitor_cfg_asserts.sv
// Checker for the monitor configuration block, bound to its top module.
// Assumes single-cycle register writes on MCLK; shadows track written register fields.
`timescale 1ns/1ns
`include "monitor_map.svh"
module monitor_cfg_checker (
  input wire logic                  MCLK,
  input wire logic                  RST,
  input wire monitor_pkg::reg_req_t REG_REQ,
  input wire monitor_pkg::conv_t    TEMP_CONV,
  input wire logic                  RESET_REQ,
  input wire logic                  SHARED_PIN_O,
  input wire logic                  SHARED_PIN_OE,
  input wire logic                  INT_N,
  input wire logic                  TACH_INPUT_TWO_LEVEL_MODE,
  input wire logic [3:0]            TACH_INPUT_ONE_DIVISOR,
  input wire logic [3:0]            TACH_INPUT_TWO_DIVISOR,
  input wire logic                  TEMP_HIRES
);
  import monitor_pkg::*;
  logic [1:0] pin_mode_reg;
  logic [1:0] cfg_reg;
  logic [7:0] mask_reg;
  logic       fan_wr;
  logic       cfg_wr;
  assign fan_wr = REG_REQ.wr && REG_REQ.addr == `ADDR_FAN_DIV;
  assign cfg_wr = REG_REQ.wr && REG_REQ.addr == `ADDR_ALARM_CFG;
  // Shadows, since register contents are not visible at the ports
  always_ff @(posedge MCLK) begin
    if (RST) pin_mode_reg <= 2'h1;
    else if (fan_wr) pin_mode_reg <= REG_REQ.wdata[7:6];
  end
  always_ff @(posedge MCLK) begin
    if (RST) cfg_reg <= 2'h0;
    else if (cfg_wr) cfg_reg <= REG_REQ.wdata[2:1];
  end
  always_ff @(posedge MCLK) begin
    if (RST) mask_reg <= 8'h00;
    else if (REG_REQ.wr && REG_REQ.addr == `ADDR_MASK2) mask_reg <= REG_REQ.wdata;
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  chk_fan_follow:
    assert property (fan_wr |-> ##2 TACH_INPUT_ONE_DIVISOR == 4'h1 << $past(REG_REQ.wdata[3:2], 2)
      && TACH_INPUT_TWO_DIVISOR == 4'h1 << $past(REG_REQ.wdata[5:4], 2) && TACH_INPUT_TWO_LEVEL_MODE == $past(REG_REQ.wdata[1], 2))
      else $error("fan controls do not follow the write");
  chk_hires_follow:
    assert property (cfg_wr |-> ##2 TEMP_HIRES == $past(REG_REQ.wdata[3], 2)) else $error("resolution mismatch");
  chk_open_drain:
    assert property (SHARED_PIN_O == 1'b0) else $error("shared pin driven high");
  chk_pin_disabled:
    assert property (pin_mode_reg == 2'h0 && $past(pin_mode_reg) == 2'h0 |-> !SHARED_PIN_OE)
      else $error("disabled pin pulled");
  chk_reset_pin:
    assert property (pin_mode_reg[1] && $past(pin_mode_reg[1]) |-> SHARED_PIN_OE == $past(RESET_REQ))
      else $error("reset pin does not follow request");
  chk_hot_irq:
    assert property (TEMP_CONV.done && TEMP_CONV.hot_over && !mask_reg[0] && !mask_reg[6] |-> ##2 !INT_N)
      else $error("hot event raised no interrupt");
  chk_all_masked:
    assert property (&{mask_reg[5], mask_reg[3:2], mask_reg[0]} |=> INT_N) else $error("masked interrupt seen");
  chk_alarm_pin:
    assert property (pin_mode_reg == 2'h1 && !cfg_reg[1] && TEMP_CONV.done && TEMP_CONV.alarm_over
      |-> ##2 SHARED_PIN_OE == !cfg_reg[0]) else $error("alarm pin not active");
endmodule // monitor_cfg_checker

bind monitor_irq_fan_alarm_config monitor_cfg_checker chk (.MCLK, .RST, .REG_REQ, .TEMP_CONV, .RESET_REQ,
  .SHARED_PIN_O, .SHARED_PIN_OE, .INT_N, .TACH_INPUT_TWO_LEVEL_MODE, .TACH_INPUT_ONE_DIVISOR, .TACH_INPUT_TWO_DIVISOR, .TEMP_HIRES);

// ===== dv/monitor_irq_fan_alarm_config_tb_top.sv
// Self-checking bench for the monitor configuration block.
// Assumes the register request protocol of the block and a pulled-up shared pin.
`timescale 1ns/1ns
`include "monitor_map.svh"
module monitor_irq_fan_alarm_config_tb_top;
  import monitor_pkg::*;
  logic       MCLK = 1'b0;
  logic       RST = 1'b1;
  reg_req_t   REG_REQ = '0;
  conv_t      TEMP_CONV = '0;
  logic       RESET_REQ = 1'b0;
  logic       TACH_INPUT_ONE_LIMIT_HIT = 1'b0;
  logic       TACH_INPUT_TWO_LIMIT_HIT = 1'b0;
  logic       TACH_INPUT_ONE = 1'b1;
  logic       TACH_INPUT_TWO = 1'b0;
  logic [7:0] REG_RDATA;
  logic       SHARED_PIN_I, SHARED_PIN_O, SHARED_PIN_OE, INT_N, TEMP_HIRES, CONV_START;
  logic       TACH_INPUT_ONE_LEVEL_MODE, TACH_INPUT_TWO_LEVEL_MODE;
  logic [3:0] TACH_INPUT_ONE_DIVISOR, TACH_INPUT_TWO_DIVISOR;
  int         miscompares = 0;
  int         checks = 0;
  int         cycles = 0;
  // Short conversion periods keep the run brief
  monitor_irq_fan_alarm_config #(.CONV8_CYCLES(20), .CONV11_CYCLES(50)) uut (
    .MCLK(MCLK), .RST(RST), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .TEMP_CONV(TEMP_CONV),
    .TACH_INPUT_ONE_LIMIT_HIT(TACH_INPUT_ONE_LIMIT_HIT), .TACH_INPUT_TWO_LIMIT_HIT(TACH_INPUT_TWO_LIMIT_HIT), .RESET_REQ(RESET_REQ),
    .TACH_INPUT_ONE(TACH_INPUT_ONE),
    .TACH_INPUT_TWO(TACH_INPUT_TWO), .CPU_VOLTAGE_ID_PINS(4'hA), .SHARED_PIN_I(SHARED_PIN_I),
    .SHARED_PIN_O(SHARED_PIN_O), .SHARED_PIN_OE(SHARED_PIN_OE), .INT_N(INT_N),
    .TACH_INPUT_ONE_LEVEL_MODE(TACH_INPUT_ONE_LEVEL_MODE), .TACH_INPUT_TWO_LEVEL_MODE(TACH_INPUT_TWO_LEVEL_MODE), .TACH_INPUT_ONE_DIVISOR(TACH_INPUT_ONE_DIVISOR),
    .TACH_INPUT_TWO_DIVISOR(TACH_INPUT_TWO_DIVISOR), .TEMP_HIRES(TEMP_HIRES), .CONV_START(CONV_START));
  shared_pin_board brd (.pin_oe(SHARED_PIN_OE), .pin_o(SHARED_PIN_O), .pin_level(SHARED_PIN_I));
  initial begin
    forever #4 MCLK = ~MCLK;
  end
  // Free-running tach two pulses, never aligned with MCLK edges
  initial begin
    #3;
    forever #32 TACH_INPUT_TWO = ~TACH_INPUT_TWO;
  end
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      wrap_up;
    end
  end
  task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    REG_REQ <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge MCLK);
    REG_REQ.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge MCLK);
    REG_REQ <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge MCLK);
    REG_REQ.rd <= 1'b0;
    repeat (2) @(posedge MCLK);
    #1 d = REG_RDATA;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    cmp($sformatf("register %h", a), exp, d);
  endtask
  task automatic conv(input logic o, input logic b, input logic [3:0] f);
    @(posedge MCLK);
    TEMP_CONV <= '{done: 1'b1, hot_over: o, hot_below: b, alarm_over: o, alarm_below: b, frac: f};
    @(posedge MCLK);
    TEMP_CONV.done <= 1'b0;
    repeat (3) @(posedge MCLK);
    #1;
  endtask
  // Cycles from one conversion start pulse to the next; the pulse stands one cycle
  task automatic start_gap(input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    @(posedge MCLK);
    #1;
    while (CONV_START !== 1'b1) begin
      @(posedge MCLK);
      #1;
    end
    @(posedge MCLK);
    #1;
    n = 8'h01;
    while (CONV_START !== 1'b1) begin
      @(posedge MCLK);
      #1;
      n = n + 8'h01;
    end
    cmp("start spacing", exp, n);
  endtask
  initial begin
    logic [7:0] v;
    repeat (12) @(posedge MCLK);
    RST <= 1'b0;
    repeat (6) @(posedge MCLK);
    rchk(`ADDR_FAN_DIV, 8'h5A);
    rchk(`ADDR_ALARM_CFG, 8'h01);
    rchk(`ADDR_MASK2, 8'h00);
    // Bench runs 20-cycle 8-bit and 50-cycle 11-bit conversion periods
    start_gap(8'h14);
    cmp("tach_input_one divisor", 8'h04, {4'h0, TACH_INPUT_ONE_DIVISOR});
    cmp("tach_input_two level", 8'h01, {7'h00, TACH_INPUT_TWO_LEVEL_MODE});
    RESET_REQ <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      v = {4{i[1:0]}};
      wr(`ADDR_FAN_DIV, v);
      rchk(`ADDR_FAN_DIV, v);
      cmp("tach_input_one divisor", 8'h01 << i, {4'h0, TACH_INPUT_ONE_DIVISOR});
      cmp("tach_input_two divisor", 8'h01 << i, {4'h0, TACH_INPUT_TWO_DIVISOR});
      cmp("tach_input_one level", {7'h00, i[0]}, {7'h00, TACH_INPUT_ONE_LEVEL_MODE});
      cmp("pin enable", {7'h00, i[1]}, {7'h00, SHARED_PIN_OE});
    end
    RESET_REQ <= 1'b0;
    wr(`ADDR_FAN_DIV, 8'h45);
    rd(`ADDR_STATUS2, v);
    TACH_INPUT_ONE <= 1'b0;
    repeat (4) @(posedge MCLK);
    TACH_INPUT_ONE <= 1'b1;
    repeat (4) @(posedge MCLK);
    rchk(`ADDR_STATUS2, 8'h04);
    rchk(`ADDR_STATUS2, 8'h00);
    // Count mode takes the limit flag; level mode ignores it
    TACH_INPUT_ONE_LIMIT_HIT <= 1'b1;
    TACH_INPUT_TWO_LIMIT_HIT <= 1'b1;
    @(posedge MCLK);
    TACH_INPUT_ONE_LIMIT_HIT <= 1'b0;
    TACH_INPUT_TWO_LIMIT_HIT <= 1'b0;
    rchk(`ADDR_STATUS2, 8'h08);
    conv(1'b1, 1'b0, 4'hB);
    cmp("int line", 8'h00, {7'h00, INT_N});
    cmp("pin enable", 8'h01, {7'h00, SHARED_PIN_OE});
    rchk(`ADDR_ALARM_CFG, 8'h80);
    rchk(`ADDR_STATUS2, 8'h21);
    cmp("int line", 8'h01, {7'h00, INT_N});
    conv(1'b1, 1'b0, 4'h0);
    rchk(`ADDR_STATUS2, 8'h21);
    conv(1'b0, 1'b1, 4'h0);
    rchk(`ADDR_STATUS2, 8'h00);
    rchk(`ADDR_ALARM_CFG, 8'h01);
    // Upper nibble and bit 0 of the write must be ignored
    wr(`ADDR_ALARM_CFG, 8'hFB);
    // Also gives the pin read-back time to reach bit 0 before it is read
    start_gap(8'h32);
    rchk(`ADDR_ALARM_CFG, 8'h0A);
    cmp("hires", 8'h01, {7'h00, TEMP_HIRES});
    conv(1'b0, 1'b1, 4'hB);
    rchk(`ADDR_ALARM_CFG, 8'hBA);
    wr(`ADDR_ALARM_CFG, 8'h00);
    wr(`ADDR_MASK2, 8'hC0);
    for (int i = 0; i < 5; i++) begin
      conv(i != 2 && i != 3, i == 2 || i == 3, 4'h0);
      rchk(`ADDR_STATUS2, (i == 1 || i == 3) ? 8'h00 : 8'h21);
    end
    wr(`ADDR_MASK2, 8'h2D);
    conv(1'b1, 1'b0, 4'h0);
    cmp("int line", 8'h01, {7'h00, INT_N});
    rchk(`ADDR_STATUS2, 8'h21);
    // One-time pin mode holds until a status read, unlike the comparator zone
    wr(`ADDR_ALARM_CFG, 8'h04);
    conv(1'b1, 1'b0, 4'h0);
    cmp("pin enable", 8'h01, {7'h00, SHARED_PIN_OE});
    rchk(`ADDR_STATUS2, 8'h21);
    cmp("pin enable", 8'h00, {7'h00, SHARED_PIN_OE});
    rchk(8'h7F, 8'h00);
    wrap_up;
  end
endmodule // monitor_irq_fan_alarm_config_tb_top

// ===== dv/shared_pin_board.sv
// Board model of the shared open-drain pin and its pull-up.
// Assumes the block pulls the pin low while its enable is high.
`timescale 1ns/1ns
module shared_pin_board (
  // Block side
  input  wire logic pin_oe,
  input  wire logic pin_o,
  // Wire level
  output logic      pin_level
);
  // Pull-up holds the wire high whenever nobody pulls
  assign pin_level = pin_oe ? pin_o : 1'b1;
endmodule // shared_pin_board

// ===== hdl/monitor_irq_fan_alarm_config.sv
// Interrupt mask 2, fan mode/divisor/pin select and alarm configuration registers with their event logic.
// Assumes a serial bus engine on MCLK issuing single-cycle register requests, and comparators on MCLK.
//
// Summary of operation
// - Mask 2 bit 5 set keeps the alarm status bit off the interrupt output.
// - Default mode: status sets each conversion above hot until below hysteresis.
// - One-time mode: single event when temperature first rises above the hot limit.
// - One-time mode: then silent until below hysteresis, where one more event occurs.
// - One-time mode: then silent until above hot again; reads always clear.
// - Fan register bits 0 and 1: one is level input, zero is pulse counting.
// - Bits 3:2 give fan one divisor 1, 2, 4 or 8.
// - Bits 5:4 give fan two divisor 1, 2, 4 or 8.
// - Bit 2 sets level polarity: one active-low, zero active-high.
// - Bit 6 one with bit 7 zero makes the shared pin the alarm output.
// - Bit 7 one makes the shared pin a reset output.
// - Bits 6 and 7 both zero disable the shared pin.
// - Fan register powers up with 0101 on top and voltage-id pins below.
// - Alarm config bit 0 is read-only and mirrors the pin in alarm mode.
// - Alarm config bit 1 selects polarity; the pin is always open-drain.
// - Alarm config bit 2: one is one-time mode, zero comparator mode.
// - Bit 3 selects 8-bit 100 ms or 11-bit 2 s conversions.
// - 11-bit mode: bits 7:4 hold the low temperature nibble.
// - 8-bit mode: bit 7 holds the 0.5 degree bit, bits 6:4 read zero.
// - Alarm config register powers up as 0000 0001.
// - Mask 2 powers up all zero.
// - Status 2 bit 5 flags alarm limit crossing, mode from mask 2 bit 7.
`timescale 1ns/1ns
`include "monitor_map.svh"

module temp_event_tracker (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               done,
  input  wire logic               over,
  input  wire logic               below,
  input  wire logic               one_time,
  output logic                    event_pulse,
  output logic                    in_alarm
);
  import monitor_pkg::*;

  track_state_t state_reg;
  track_state_t state_next;

  always_comb begin
    state_next  = state_reg;
    event_pulse = 1'b0;
    case (state_reg)
      WAIT_HIGH: begin
        if (done && over) begin
          state_next  = WAIT_LOW;
          event_pulse = 1'b1;
        end
      end
      WAIT_LOW: begin
        if (done && below) begin
          state_next  = WAIT_HIGH;
          event_pulse = one_time;
        end else if (done && !one_time) begin
          event_pulse = 1'b1;
        end
      end
      default: state_next = WAIT_HIGH;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= WAIT_HIGH;
    end else begin
      state_reg <= state_next;
    end
  end

  assign in_alarm = (state_reg == WAIT_LOW);
endmodule // temp_event_tracker

module monitor_irq_fan_alarm_config #(
  parameter int unsigned CONV8_CYCLES  = `CONV8_CYCLES,
  parameter int unsigned CONV11_CYCLES = `CONV11_CYCLES
) (
  // Clock and reset
  input  wire logic               MCLK,
  input  wire logic               RST,
  // Register requests from the serial bus engine
  input  wire monitor_pkg::reg_req_t REG_REQ,
  output logic [7:0]              REG_RDATA,
  // Conversion results from the comparators
  input  wire monitor_pkg::conv_t TEMP_CONV,
  input  wire logic               TACH_INPUT_ONE_LIMIT_HIT,
  input  wire logic               TACH_INPUT_TWO_LIMIT_HIT,
  input  wire logic               RESET_REQ,
  // Pins
  input  wire logic               TACH_INPUT_ONE,
  input  wire logic               TACH_INPUT_TWO,
  input  wire logic [3:0]         CPU_VOLTAGE_ID_PINS,
  input  wire logic               SHARED_PIN_I,
  output logic                    SHARED_PIN_O,
  output logic                    SHARED_PIN_OE,
  output logic                    INT_N,
  // Controls to the fan counters and conversion engine
  output logic                    TACH_INPUT_ONE_LEVEL_MODE,
  output logic                    TACH_INPUT_TWO_LEVEL_MODE,
  output logic [3:0]              TACH_INPUT_ONE_DIVISOR,
  output logic [3:0]              TACH_INPUT_TWO_DIVISOR,
  output logic                    TEMP_HIRES,
  output logic                    CONV_START
);
  import monitor_pkg::*;

  logic [7:0]  mask2_reg;
  logic [7:0]  fan_div_reg;
  logic [7:0]  alarm_cfg_reg;
  logic [7:0]  status_reg;
  logic [7:0]  status_next;
  logic [7:0]  set_bits;
  logic [1:0]  vid_wait_reg;
  logic        vid_loaded_reg;
  logic [31:0] conv_cnt_reg;
  logic        alarm_latch_reg;
  logic [3:0]  vid_meta_reg;
  logic [3:0]  vid_sync_reg;
  logic [2:0]  pin_meta_reg;
  logic [2:0]  pin_sync_reg;
  logic        hot_event;
  logic        alarm_event;
  logic        alarm_in_zone;
  logic        alarm_active;
  logic        wr_fan;
  logic        rd_status;
  logic        tach_input_one_lvl_hit;
  logic        tach_input_two_lvl_hit;

  // Pins pass two flops before use; only the second stage is read
  always_ff @(posedge MCLK) begin
    vid_meta_reg <= CPU_VOLTAGE_ID_PINS;
    vid_sync_reg <= vid_meta_reg;
    pin_meta_reg <= {SHARED_PIN_I, TACH_INPUT_TWO, TACH_INPUT_ONE};
    pin_sync_reg <= pin_meta_reg;
  end

  temp_event_tracker u_hot (
    .clk         (MCLK),
    .rst         (RST),
    .done        (TEMP_CONV.done),
    .over        (TEMP_CONV.hot_over),
    .below       (TEMP_CONV.hot_below),
    .one_time    (mask2_reg[`M2_HOT_MODE_BIT]),
    .event_pulse (hot_event),
    .in_alarm    ()
  );

  temp_event_tracker u_alarm (
    .clk         (MCLK),
    .rst         (RST),
    .done        (TEMP_CONV.done),
    .over        (TEMP_CONV.alarm_over),
    .below       (TEMP_CONV.alarm_below),
    .one_time    (mask2_reg[`M2_ALARM_MODE_BIT]),
    .event_pulse (alarm_event),
    .in_alarm    (alarm_in_zone)
  );

  assign wr_fan    = REG_REQ.wr && (REG_REQ.addr == `ADDR_FAN_DIV);
  assign rd_status = REG_REQ.rd && (REG_REQ.addr == `ADDR_STATUS2);

  // Level-sensitive fan inputs flag on their active level
  assign tach_input_one_lvl_hit = pin_sync_reg[0] ^ fan_div_reg[`FD_POL_BIT];
  assign tach_input_two_lvl_hit = pin_sync_reg[1] ^ fan_div_reg[`FD_POL_BIT];

  always_comb begin
    set_bits                = 8'h00;
    set_bits[`ST_HOT_BIT]   = hot_event;
    set_bits[`ST_ALARM_BIT] = alarm_event;
    set_bits[`ST_TACH_INPUT_ONE_BIT]  = fan_div_reg[`FD_MODE1_BIT] ? tach_input_one_lvl_hit : TACH_INPUT_ONE_LIMIT_HIT;
    set_bits[`ST_TACH_INPUT_TWO_BIT]  = fan_div_reg[`FD_MODE2_BIT] ? tach_input_two_lvl_hit : TACH_INPUT_TWO_LIMIT_HIT;
    status_next = status_reg;
    if (rd_status) begin
      status_next = 8'h00;
    end
    // A new event in the clearing cycle survives
    status_next = status_next | set_bits;
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      status_reg <= 8'h00;
    end else begin
      status_reg <= status_next;
    end
  end

  // Masked status gates the main interrupt
  always_ff @(posedge MCLK) begin
    if (RST) begin
      INT_N <= 1'b1;
    end else begin
      INT_N <= ~|(status_reg & ~mask2_reg);
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      mask2_reg <= `MASK2_RESET;
    end else if (REG_REQ.wr && (REG_REQ.addr == `ADDR_MASK2)) begin
      mask2_reg <= REG_REQ.wdata;
    end
  end

  // Voltage-id straps are caught once the synchroniser has filled after reset
  always_ff @(posedge MCLK) begin
    if (RST) begin
      fan_div_reg    <= {`FAN_DIV_RESET_HI, 4'h0};
      vid_wait_reg   <= 2'h0;
      vid_loaded_reg <= 1'b0;
    end else if (wr_fan) begin
      fan_div_reg    <= REG_REQ.wdata;
      vid_loaded_reg <= 1'b1;
    end else if (!vid_loaded_reg) begin
      if (vid_wait_reg == `VID_SETTLE_CYCLES) begin
        fan_div_reg[3:0] <= vid_sync_reg;
        vid_loaded_reg   <= 1'b1;
      end else begin
        vid_wait_reg <= vid_wait_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      alarm_cfg_reg <= `ALARM_CFG_RESET;
    end else begin
      if (fan_div_reg[`FD_PIN_ALARM_BIT] && !fan_div_reg[`FD_PIN_RESET_BIT]) begin
        alarm_cfg_reg[`AC_PIN_STATE_BIT] <= pin_sync_reg[2];
      end else begin
        alarm_cfg_reg[`AC_PIN_STATE_BIT] <= 1'b0;
      end
      if (REG_REQ.wr && (REG_REQ.addr == `ADDR_ALARM_CFG)) begin
        alarm_cfg_reg[3:1] <= REG_REQ.wdata[3:1];
      end
      if (TEMP_CONV.done) begin
        if (alarm_cfg_reg[`AC_HIRES_BIT]) begin
          alarm_cfg_reg[7:4] <= TEMP_CONV.frac;
        end else begin
          alarm_cfg_reg[7:4] <= {TEMP_CONV.frac[3], 3'h0};
        end
      end
    end
  end

  // One-time alarm holds until status is read; comparator follows the zone
  always_ff @(posedge MCLK) begin
    if (RST) begin
      alarm_latch_reg <= 1'b0;
    end else if (alarm_event) begin
      alarm_latch_reg <= 1'b1;
    end else if (rd_status) begin
      alarm_latch_reg <= 1'b0;
    end
  end

  assign alarm_active = alarm_cfg_reg[`AC_ONE_TIME_BIT] ? alarm_latch_reg : alarm_in_zone;

  // Open-drain: only ever pulls low; a high level is a release
  always_ff @(posedge MCLK) begin
    SHARED_PIN_O <= 1'b0;
    if (RST) begin
      SHARED_PIN_OE <= 1'b0;
    end else if (fan_div_reg[`FD_PIN_RESET_BIT]) begin
      SHARED_PIN_OE <= RESET_REQ;
    end else if (fan_div_reg[`FD_PIN_ALARM_BIT]) begin
      SHARED_PIN_OE <= alarm_active ^ alarm_cfg_reg[`AC_POL_BIT];
    end else begin
      SHARED_PIN_OE <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      TACH_INPUT_ONE_LEVEL_MODE <= 1'b0;
      TACH_INPUT_TWO_LEVEL_MODE <= 1'b0;
      TACH_INPUT_ONE_DIVISOR    <= 4'h1;
      TACH_INPUT_TWO_DIVISOR    <= 4'h1;
      TEMP_HIRES      <= 1'b0;
    end else begin
      TACH_INPUT_ONE_LEVEL_MODE <= fan_div_reg[`FD_MODE1_BIT];
      TACH_INPUT_TWO_LEVEL_MODE <= fan_div_reg[`FD_MODE2_BIT];
      TACH_INPUT_ONE_DIVISOR    <= 4'h1 << fan_div_reg[3:2];
      TACH_INPUT_TWO_DIVISOR    <= 4'h1 << fan_div_reg[5:4];
      TEMP_HIRES      <= alarm_cfg_reg[`AC_HIRES_BIT];
    end
  end

  // Conversion pacing; a resolution change takes effect at the next start
  always_ff @(posedge MCLK) begin
    if (RST) begin
      conv_cnt_reg <= 32'h0;
      CONV_START   <= 1'b0;
    end else if (conv_cnt_reg == 32'h0) begin
      conv_cnt_reg <= alarm_cfg_reg[`AC_HIRES_BIT] ? CONV11_CYCLES - 32'h1 : CONV8_CYCLES - 32'h1;
      CONV_START   <= 1'b1;
    end else begin
      conv_cnt_reg <= conv_cnt_reg - 32'h1;
      CONV_START   <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_REQ.rd) begin
      if (REG_REQ.addr == `ADDR_STATUS2) begin
        REG_RDATA <= status_reg;
      end else if (REG_REQ.addr == `ADDR_FAN_DIV) begin
        REG_RDATA <= fan_div_reg;
      end else if (REG_REQ.addr == `ADDR_ALARM_CFG) begin
        REG_RDATA <= alarm_cfg_reg;
      end else if (REG_REQ.addr == `ADDR_MASK2) begin
        REG_RDATA <= mask2_reg;
      end else begin
        REG_RDATA <= 8'h00;
      end
    end
  end
endmodule // monitor_irq_fan_alarm_config

// ===== hdl/monitor_map.svh
// Offsets, field positions, reset values and timing counts of the monitor configuration block.
// Assumes a 125 MHz block clock; included by the design, the checker and the bench.
`ifndef MONITOR_MAP_SVH
`define MONITOR_MAP_SVH

`define ADDR_STATUS2        8'h02
`define ADDR_FAN_DIV        8'h05
`define ADDR_ALARM_CFG      8'h06
`define ADDR_MASK2          8'h44

`define MASK2_RESET         8'h00
`define FAN_DIV_RESET_HI    4'h5
`define ALARM_CFG_RESET     8'h01

`define ST_HOT_BIT          0
`define ST_TACH_INPUT_ONE_BIT         2
`define ST_TACH_INPUT_TWO_BIT         3
`define ST_ALARM_BIT        5

`define M2_HOT_MODE_BIT     6
`define M2_ALARM_MODE_BIT   7

`define FD_MODE1_BIT        0
`define FD_MODE2_BIT        1
`define FD_POL_BIT          2
`define FD_PIN_ALARM_BIT    6
`define FD_PIN_RESET_BIT    7

`define AC_PIN_STATE_BIT    0
`define AC_POL_BIT          1
`define AC_ONE_TIME_BIT     2
`define AC_HIRES_BIT        3

`define CLK_KHZ             125000
`define CONV8_TIME_MS       100
`define CONV11_TIME_MS      2000
`define CONV8_CYCLES        (`CONV8_TIME_MS * `CLK_KHZ)
`define CONV11_CYCLES       (`CONV11_TIME_MS * `CLK_KHZ)

`define VID_SETTLE_CYCLES   2'h2

`endif

// ===== hdl/monitor_pkg.sv
// Types shared by the monitor configuration block and its bench.
// Assumes the conversion engine and comparators sit on the same clock.
package monitor_pkg;

  // One conversion result as presented by the comparator logic
  typedef struct packed {
    logic       done;
    logic       hot_over;
    logic       hot_below;
    logic       alarm_over;
    logic       alarm_below;
    logic [3:0] frac;
  } conv_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    WAIT_HIGH = 2'b01,
    WAIT_LOW  = 2'b10
  } track_state_t;

endpackage
